/* src/usp_device.sv */
// Purpose: serial port with 8-bit and 9-bit frames and address filter
// Assumes: serial input is synchronous to ref_clk_i
// Notes: one select line picks the control or the buffer register
`include "usp_cfg.svh"
module usp_device (
    input wire logic ref_clk_i, // system clock
    input wire logic reset_i, // async reset, active high
    usp_if.dev link, // serial line pair
    input wire logic sfr_sel_i, // 0 control, 1 buffer
    input wire logic sfr_wr_i, // write strobe, one cycle
    input wire usp_pkg::usp_byte_t sfr_wdata_i, // write data
    output usp_pkg::usp_byte_t sfr_rdata_o, // read data, one cycle later
    input wire usp_pkg::usp_byte_t baud_reload_value_i, // timer reload
    output logic irq_req_o // serial interrupt request level
);
    import usp_pkg::*;
    localparam logic [7:0] CTRL_RST = `USP_CTRL_RST;
    logic frame_length_select_ff;
    logic multiproc_filter_enable_ff;
    logic receive_enable_bit_ff;
    logic transmit_ninth_bit_ff;
    logic received_ninth_bit_ff;
    logic tx_done_flag_ff;
    logic rx_done_flag_ff;
    usp_byte_t serial_buffer_reg_ff;
    usp_byte_t tx_shift_ff;
    usp_byte_t rx_shift_ff;
    usp_state_e tx_state_ff;
    usp_state_e rx_state_ff;
    logic [2:0] tx_cnt_ff;
    logic [2:0] rx_cnt_ff;
    logic txd_ff;
    logic rx_ninth_ff;
    logic wr_ctrl;
    logic wr_buf;
    logic tx_go;
    logic tx_bit;
    logic tx_fin;
    logic rx_go;
    logic rx_half;
    logic rx_end;
    logic rx_extra;
    logic rx_load;
    usp_byte_t ctrl_rd;

    assign wr_ctrl = sfr_wr_i && (sfr_sel_i == `USP_SEL_CTRL);
    assign wr_buf = sfr_wr_i && (sfr_sel_i == `USP_SEL_BUF);
    assign link.dev_line = txd_ff;

    // writes during a busy frame are dropped so the frame stays intact
    assign tx_go = wr_buf && (tx_state_ff == USP_IDLE);
    assign tx_fin = tx_bit && ((tx_state_ff == USP_DATA && tx_cnt_ff == `USP_LAST_BIT
                    && !frame_length_select_ff) || tx_state_ff == USP_NINTH);

    usp_baud_gen #(
        .W(8)
    ) u_tx_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .restart_i(tx_go),
        .reload_i(baud_reload_value_i),
        .half_o(),
        .bit_o(tx_bit)
    );

    usp_baud_gen #(
        .W(8)
    ) u_rx_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .restart_i(rx_go),
        .reload_i(baud_reload_value_i),
        .half_o(rx_half),
        .bit_o()
    );

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_state_ff <= USP_IDLE;
            tx_shift_ff <= `USP_BUF_RST;
            tx_cnt_ff <= 3'h0;
            txd_ff <= 1'b1;
        end else begin
            case (tx_state_ff)
                USP_IDLE: begin
                    if (tx_go) begin
                        tx_shift_ff <= sfr_wdata_i;
                        txd_ff <= 1'b0;
                        tx_state_ff <= USP_START;
                    end
                end
                USP_START: begin
                    if (tx_bit) begin
                        txd_ff <= tx_shift_ff[0];
                        tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
                        tx_cnt_ff <= 3'h0;
                        tx_state_ff <= USP_DATA;
                    end
                end
                USP_DATA: begin
                    if (tx_bit) begin
                        if (tx_cnt_ff == `USP_LAST_BIT) begin
                            if (frame_length_select_ff) begin
                                txd_ff <= transmit_ninth_bit_ff;
                                tx_state_ff <= USP_NINTH;
                            end else begin
                                txd_ff <= 1'b1;
                                tx_state_ff <= USP_STOP;
                            end
                        end else begin
                            txd_ff <= tx_shift_ff[0];
                            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
                            tx_cnt_ff <= tx_cnt_ff + 3'h1;
                        end
                    end
                end
                USP_NINTH: begin
                    if (tx_bit) begin
                        txd_ff <= 1'b1;
                        tx_state_ff <= USP_STOP;
                    end
                end
                USP_STOP: begin
                    if (tx_bit) begin
                        tx_state_ff <= USP_IDLE;
                    end
                end
                default: begin
                    txd_ff <= 1'b1;
                    tx_state_ff <= USP_IDLE;
                end
            endcase
        end
    end

    // a frame already under way finishes even if enable is dropped
    assign rx_go = (rx_state_ff == USP_IDLE) && receive_enable_bit_ff
                   && !link.peer_line;
    assign rx_end = rx_half && (rx_state_ff == USP_STOP);
    assign rx_extra = frame_length_select_ff ? rx_ninth_ff : link.peer_line;
    assign rx_load = rx_end && !rx_done_flag_ff
                     && (!multiproc_filter_enable_ff || rx_extra);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_state_ff <= USP_IDLE;
            rx_shift_ff <= `USP_BUF_RST;
            rx_cnt_ff <= 3'h0;
            rx_ninth_ff <= 1'b0;
        end else begin
            case (rx_state_ff)
                USP_IDLE: begin
                    if (rx_go) begin
                        rx_state_ff <= USP_START;
                    end
                end
                USP_START: begin
                    if (rx_half) begin
                        // a start bit gone high by mid-bit was a glitch
                        rx_state_ff <= link.peer_line ? USP_IDLE : USP_DATA;
                        rx_cnt_ff <= 3'h0;
                    end
                end
                USP_DATA: begin
                    if (rx_half) begin
                        rx_shift_ff <= {link.peer_line, rx_shift_ff[7:1]};
                        if (rx_cnt_ff == `USP_LAST_BIT) begin
                            rx_state_ff <= frame_length_select_ff ? USP_NINTH : USP_STOP;
                        end else begin
                            rx_cnt_ff <= rx_cnt_ff + 3'h1;
                        end
                    end
                end
                USP_NINTH: begin
                    if (rx_half) begin
                        rx_ninth_ff <= link.peer_line;
                        rx_state_ff <= USP_STOP;
                    end
                end
                USP_STOP: begin
                    if (rx_half) begin
                        rx_state_ff <= USP_IDLE;
                    end
                end
                default: begin
                    rx_state_ff <= USP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            serial_buffer_reg_ff <= `USP_BUF_RST;
            received_ninth_bit_ff <= CTRL_RST[`USP_B_RB8];
        end else if (rx_load) begin
            serial_buffer_reg_ff <= rx_shift_ff;
            received_ninth_bit_ff <= rx_extra;
        end else if (wr_ctrl) begin
            received_ninth_bit_ff <= sfr_wdata_i[`USP_B_RB8];
        end
    end

    // hardware set wins over a clearing write in the same cycle
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_done_flag_ff <= CTRL_RST[`USP_B_TI];
            rx_done_flag_ff <= CTRL_RST[`USP_B_RI];
        end else begin
            if (tx_fin) begin
                tx_done_flag_ff <= 1'b1;
            end else if (wr_ctrl && !sfr_wdata_i[`USP_B_TI]) begin
                tx_done_flag_ff <= 1'b0;
            end
            if (rx_load) begin
                rx_done_flag_ff <= 1'b1;
            end else if (wr_ctrl && !sfr_wdata_i[`USP_B_RI]) begin
                rx_done_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_length_select_ff <= CTRL_RST[`USP_B_MODE];
            multiproc_filter_enable_ff <= CTRL_RST[`USP_B_MCE];
            receive_enable_bit_ff <= CTRL_RST[`USP_B_REN];
            transmit_ninth_bit_ff <= CTRL_RST[`USP_B_TB8];
        end else if (wr_ctrl) begin
            frame_length_select_ff <= sfr_wdata_i[`USP_B_MODE];
            multiproc_filter_enable_ff <= sfr_wdata_i[`USP_B_MCE];
            receive_enable_bit_ff <= sfr_wdata_i[`USP_B_REN];
            transmit_ninth_bit_ff <= sfr_wdata_i[`USP_B_TB8];
        end
    end

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[`USP_B_MODE] = frame_length_select_ff;
        ctrl_rd[`USP_B_SPARE] = `USP_SPARE_READ;
        ctrl_rd[`USP_B_MCE] = multiproc_filter_enable_ff;
        ctrl_rd[`USP_B_REN] = receive_enable_bit_ff;
        ctrl_rd[`USP_B_TB8] = transmit_ninth_bit_ff;
        ctrl_rd[`USP_B_RB8] = received_ninth_bit_ff;
        ctrl_rd[`USP_B_TI] = tx_done_flag_ff;
        ctrl_rd[`USP_B_RI] = rx_done_flag_ff;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sfr_rdata_o <= `USP_CTRL_RST;
            irq_req_o <= 1'b0;
        end else begin
            sfr_rdata_o <= (sfr_sel_i == `USP_SEL_BUF) ? serial_buffer_reg_ff : ctrl_rd;
            irq_req_o <= tx_done_flag_ff || rx_done_flag_ff;
        end
    end
endmodule

/* inc/usp_cfg.svh */
// Purpose: constants for the serial port (offsets, field positions, resets)
// Assumes: included by its bare name
// Notes: select codes pick one of the two serial SFRs
`ifndef USP_CFG_SVH
`define USP_CFG_SVH
`define USP_SEL_CTRL 1'h0
`define USP_SEL_BUF 1'h1
`define USP_B_MODE 7
`define USP_B_SPARE 6
`define USP_B_MCE 5
`define USP_B_REN 4
`define USP_B_TB8 3
`define USP_B_RB8 2
`define USP_B_TI 1
`define USP_B_RI 0
`define USP_CTRL_RST 8'h40
`define USP_SPARE_READ 1'h1
`define USP_BUF_RST 8'h00
`define USP_LAST_BIT 3'h7
`define USP_PEER_BIT_CYC 16
`endif

/* inc/usp_pkg.sv */
// Purpose: types shared by both serial ends
// Assumes: nothing
// Notes: states are shared by the device and the peer
package usp_pkg;
    typedef logic [7:0] usp_byte_t;
    typedef enum logic [2:0] {
        USP_IDLE,
        USP_START,
        USP_DATA,
        USP_NINTH,
        USP_STOP
    } usp_state_e;
endpackage

/* inc/usp_if.sv */
// Purpose: two-wire serial link between the device and its peer
// Assumes: each wire has one driver
// Notes: both wires idle high
interface usp_if;
    logic dev_line;
    logic peer_line;
    modport dev(output dev_line, input peer_line);
    modport peer(input dev_line, output peer_line);
endinterface

/* src/usp_baud_gen.sv */
// Purpose: 8-bit auto-reload bit timer, overflow divided by two
// Assumes: reload value held steady during a frame
// Notes: half_o marks mid-bit, bit_o marks the bit boundary
module usp_baud_gen #(
    parameter int W = 8
) (
    input wire logic ref_clk_i, // system clock
    input wire logic reset_i, // async reset, active high
    input wire logic restart_i, // force reload, phase zero
    input wire logic [W-1:0] reload_i, // auto-reload value
    output logic half_o, // pulse at first overflow of a bit
    output logic bit_o // pulse at second overflow of a bit
);
    logic [W-1:0] cnt_ff;
    logic phase_ff;
    logic ovf;

    assign ovf = !restart_i && (cnt_ff == {W{1'b1}});

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_ff <= '0;
            phase_ff <= 1'b0;
        end else if (restart_i) begin
            cnt_ff <= reload_i;
            phase_ff <= 1'b0;
        end else if (ovf) begin
            cnt_ff <= reload_i;
            phase_ff <= !phase_ff;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            half_o <= 1'b0;
            bit_o <= 1'b0;
        end else begin
            half_o <= ovf && !phase_ff;
            bit_o <= ovf && phase_ff;
        end
    end
endmodule

/* src/usp_peer.sv */
// Purpose: remote serial peer acting as multiprocessor master
// Assumes: bit period in ref_clk_i cycles matches the device timer
// Notes: receives every character, no address filtering
`include "usp_cfg.svh"
module usp_peer #(
    parameter int BIT_CYC = `USP_PEER_BIT_CYC
) (
    input wire logic ref_clk_i, // system clock
    input wire logic reset_i, // async reset, active high
    usp_if.peer link, // serial line pair
    input wire logic nine_bit_i, // 1 selects 9-bit frames
    input wire logic send_valid_i, // character offered
    output logic send_ready_o, // transmitter idle
    input wire usp_pkg::usp_byte_t send_data_i, // character to send
    input wire logic send_addr_i, // 1 marks an address character
    output logic recv_valid_o, // one-cycle pulse per character
    output usp_pkg::usp_byte_t recv_data_o, // received byte
    output logic recv_ninth_o // ninth bit, or stop bit in 8-bit
);
    import usp_pkg::*;

    localparam logic [15:0] LAST = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);

    usp_state_e tx_state_ff;
    usp_state_e rx_state_ff;
    logic [15:0] tcnt_ff;
    logic [15:0] rcnt_ff;
    logic [2:0] tbit_ff;
    logic [2:0] rbit_ff;
    usp_byte_t tsh_ff;
    usp_byte_t rsh_ff;
    logic tninth_ff;
    logic rninth_ff;
    logic line_ff;
    logic accept;
    logic tick;
    logic samp;

    assign link.peer_line = line_ff;
    assign accept = send_valid_i && send_ready_o;
    assign tick = (tcnt_ff == LAST);
    assign samp = (rcnt_ff == HALF);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tcnt_ff <= '0;
        end else if (accept || tick) begin
            tcnt_ff <= '0;
        end else begin
            tcnt_ff <= tcnt_ff + 16'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_state_ff <= USP_IDLE;
            send_ready_o <= 1'b1;
            line_ff <= 1'b1;
            tsh_ff <= `USP_BUF_RST;
            tninth_ff <= 1'b0;
            tbit_ff <= 3'h0;
        end else begin
            case (tx_state_ff)
                USP_IDLE: begin
                    if (accept) begin
                        tsh_ff <= send_data_i;
                        tninth_ff <= send_addr_i;
                        line_ff <= 1'b0;
                        send_ready_o <= 1'b0;
                        tx_state_ff <= USP_START;
                    end
                end
                USP_START: begin
                    if (tick) begin
                        line_ff <= tsh_ff[0];
                        tsh_ff <= {1'b0, tsh_ff[7:1]};
                        tbit_ff <= 3'h0;
                        tx_state_ff <= USP_DATA;
                    end
                end
                USP_DATA: begin
                    if (tick) begin
                        if (tbit_ff == `USP_LAST_BIT) begin
                            line_ff <= nine_bit_i ? tninth_ff : 1'b1;
                            tx_state_ff <= nine_bit_i ? USP_NINTH : USP_STOP;
                        end else begin
                            line_ff <= tsh_ff[0];
                            tsh_ff <= {1'b0, tsh_ff[7:1]};
                            tbit_ff <= tbit_ff + 3'h1;
                        end
                    end
                end
                USP_NINTH: begin
                    if (tick) begin
                        line_ff <= 1'b1;
                        tx_state_ff <= USP_STOP;
                    end
                end
                USP_STOP: begin
                    if (tick) begin
                        send_ready_o <= 1'b1;
                        tx_state_ff <= USP_IDLE;
                    end
                end
                default: begin
                    line_ff <= 1'b1;
                    send_ready_o <= 1'b1;
                    tx_state_ff <= USP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rcnt_ff <= '0;
        end else if (rx_state_ff == USP_IDLE || rcnt_ff == LAST) begin
            rcnt_ff <= '0;
        end else begin
            rcnt_ff <= rcnt_ff + 16'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_state_ff <= USP_IDLE;
            rsh_ff <= `USP_BUF_RST;
            rninth_ff <= 1'b0;
            rbit_ff <= 3'h0;
            recv_valid_o <= 1'b0;
            recv_data_o <= `USP_BUF_RST;
            recv_ninth_o <= 1'b0;
        end else begin
            recv_valid_o <= 1'b0;
            case (rx_state_ff)
                USP_IDLE: begin
                    if (!link.dev_line) begin
                        rx_state_ff <= USP_START;
                    end
                end
                USP_START: begin
                    if (samp) begin
                        rx_state_ff <= link.dev_line ? USP_IDLE : USP_DATA;
                        rbit_ff <= 3'h0;
                    end
                end
                USP_DATA: begin
                    if (samp) begin
                        rsh_ff <= {link.dev_line, rsh_ff[7:1]};
                        if (rbit_ff == `USP_LAST_BIT) begin
                            rx_state_ff <= nine_bit_i ? USP_NINTH : USP_STOP;
                        end else begin
                            rbit_ff <= rbit_ff + 3'h1;
                        end
                    end
                end
                USP_NINTH: begin
                    if (samp) begin
                        rninth_ff <= link.dev_line;
                        rx_state_ff <= USP_STOP;
                    end
                end
                USP_STOP: begin
                    if (samp) begin
                        recv_valid_o <= 1'b1;
                        recv_data_o <= rsh_ff;
                        recv_ninth_o <= nine_bit_i ? rninth_ff : link.dev_line;
                        rx_state_ff <= USP_IDLE;
                    end
                end
                default: begin
                    rx_state_ff <= USP_IDLE;
                end
            endcase
        end
    end
endmodule

/* dv/usp_properties.sv */
// Purpose: link and register properties of the serial port pair
// Assumes: bit time of 16 clocks, control reads keep select low
// Notes: idle count saturates, so a long idle reads as idle
module usp_properties (
    input wire logic ref_clk_i, // clock
    input wire logic reset_i, // async reset
    input wire logic dev_line_i, // device serial out
    input wire logic peer_line_i, // peer serial out
    input wire logic sfr_sel_i, // register select
    input wire logic sfr_wr_i, // write strobe
    input wire usp_pkg::usp_byte_t sfr_wdata_i, // write data
    input wire usp_pkg::usp_byte_t sfr_rdata_i, // read data
    input wire logic irq_req_i // interrupt request
);
    import usp_pkg::*;
    logic [7:0] idle_ff;
    // a 0xFF byte with the ninth bit set keeps the line high for 10 bits, so 200 clocks means truly idle
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            idle_ff <= 8'h00;
        end else if (!dev_line_i) begin
            idle_ff <= 8'h00;
        end else if (idle_ff != 8'hFF) begin
            idle_ff <= idle_ff + 8'h01;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    line_fall_bit_a: assert property ($fell(dev_line_i) |-> !dev_line_i [*8])
        else $error("device low bit too short");
    line_rise_bit_a: assert property ($rose(dev_line_i) |-> dev_line_i [*8])
        else $error("device high bit too short");
    peer_start_a: assert property ($fell(peer_line_i) |-> !peer_line_i [*8])
        else $error("peer start bit too short");
    start_at_write_a: assert property (sfr_wr_i && sfr_sel_i && idle_ff >= 8'hC8
        |=> !dev_line_i) else $error("no start bit after buffer write");
    ctrl_write_a: assert property (sfr_wr_i && !sfr_sel_i ##1 !sfr_sel_i
        |=> (sfr_rdata_i & 8'hB8) == ($past(sfr_wdata_i, 2) & 8'hB8))
        else $error("control write lost");
    irq_flags_a: assert property (!sfr_sel_i
        |=> irq_req_i == (sfr_rdata_i[1] | sfr_rdata_i[0]))
        else $error("interrupt request differs from flags");
    tx_flag_src_a: assert property (!sfr_sel_i [*3] ##0 $rose(sfr_rdata_i[1]) |-> dev_line_i)
        else $error("transmit done outside stop bit");
    rx_flag_src_a: assert property (!sfr_sel_i [*3] ##0 $rose(sfr_rdata_i[0]) |-> peer_line_i)
        else $error("receive done outside stop bit");
    // the request trails the flags by one cycle, so a clear shows two cycles after its write
    flags_hold_a: assert property (irq_req_i && !(sfr_wr_i && !sfr_sel_i)
        && !$past(sfr_wr_i && !sfr_sel_i) |=> irq_req_i)
        else $error("flag cleared without a write");
    cover property ($rose(irq_req_i));
    cover property (sfr_wr_i && sfr_sel_i && idle_ff >= 8'hC8);
    cover property ($fell(peer_line_i));
endmodule

/* dv/tb_top.sv */
// Purpose: device and peer joined by the link, driven from both user sides
// Assumes: reload 8'hF8 gives 16 clocks a bit, peer set to match
// Notes: overrun is checked by a second character with the flag still set
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import usp_pkg::*;
    logic ref_clk_i, reset_i, sel, wr, nine, sv, sa, sr, rv, rn, irq;
    usp_byte_t wd, rd, sd, rdat;
    int fails, compares;
    usp_if link();
    usp_device u_usp_device (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(link.dev),
        .sfr_sel_i(sel), .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rdata_o(rd),
        .baud_reload_value_i(8'hF8), .irq_req_o(irq));
    usp_peer #(.BIT_CYC(16)) u_usp_peer (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .link(link.peer), .nine_bit_i(nine), .send_valid_i(sv), .send_ready_o(sr),
        .send_data_i(sd), .send_addr_i(sa), .recv_valid_o(rv), .recv_data_o(rdat),
        .recv_ninth_o(rn));
    usp_properties u_usp_properties (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .dev_line_i(link.dev_line), .peer_line_i(link.peer_line), .sfr_sel_i(sel),
        .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rdata_i(rd), .irq_req_i(irq));
    task automatic final_report();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic s, input logic [7:0] d);
        @(posedge ref_clk_i);
        sel <= s;
        wr <= 1'b1;
        wd <= d;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask
    // read data is registered, so it is taken one edge after select moves
    task automatic rd_reg(input logic s, input logic [7:0] exp);
        @(posedge ref_clk_i);
        sel <= s;
        @(posedge ref_clk_i);
        #1 chk(rd, exp);
    endtask
    task automatic wait_for(input int kind, input logic lvl);
        int n;
        n = 0;
        #1;
        while (((kind == 0) ? sr : rv) !== lvl) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            if (n > 400) begin
                fails++;
                final_report();
            end
        end
    endtask
    task automatic send(input logic [7:0] d, input logic a);
        @(posedge ref_clk_i);
        sv <= 1'b1;
        sd <= d;
        sa <= a;
        wait_for(0, 1'b0);
        @(posedge ref_clk_i);
        sv <= 1'b0;
        wait_for(0, 1'b1);
    endtask
    task automatic t_reset();
        rd_reg(1'b0, 8'h40);
        rd_reg(1'b1, 8'h00);
        chk({7'h00, link.dev_line}, 8'h01);
    endtask
    task automatic t_tx(input logic nb, input logic [7:0] d, input logic b9);
        wr_reg(1'b0, {nb, 3'h0, b9, 3'h0});
        nine <= nb;
        repeat (210) @(posedge ref_clk_i);
        wr_reg(1'b1, d);
        // control on the read port so the transmit-done rise is watched live
        sel <= 1'b0;
        wait_for(1, 1'b1);
        chk(rdat, d);
        chk({7'h00, rn}, {7'h00, nb ? b9 : 1'b1});
        repeat (16) @(posedge ref_clk_i);
        rd_reg(1'b0, {nb, 3'h4, b9, 3'h2});
    endtask
    task automatic t_rx(input logic [7:0] ctl, input logic [7:0] d, input logic a,
                        input logic [7:0] ec, input logic [7:0] eb);
        wr_reg(1'b0, ctl);
        nine <= ctl[7];
        send(d, a);
        rd_reg(1'b0, ec);
        rd_reg(1'b1, eb);
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        reset_i = 1'b1;
        {sel, wr, nine, sv, sa, fails, compares} = '0;
        wd = 8'h00;
        sd = 8'h00;
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_tx(1'b0, 8'hA5, 1'b0);
        t_tx(1'b1, 8'h3C, 1'b1);
        t_tx(1'b1, 8'hC3, 1'b0);
        t_rx(8'h00, 8'h5A, 1'b0, 8'h40, 8'h00);
        t_rx(8'h10, 8'h96, 1'b0, 8'h55, 8'h96);
        t_rx(8'h11, 8'h69, 1'b0, 8'h51, 8'h96);
        t_rx(8'h30, 8'h44, 1'b0, 8'h75, 8'h44);
        t_rx(8'hB0, 8'h11, 1'b0, 8'hF0, 8'h44);
        t_rx(8'hB0, 8'h22, 1'b1, 8'hF5, 8'h22);
        t_rx(8'h90, 8'h33, 1'b0, 8'hD1, 8'h33);
        final_report();
    end
endmodule
